// File: hrpci_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module hrpci_ctrl_model (
    input wire logic sys_clk,
    input wire logic ctrlCycleEn,
    input wire logic [4:0] wlat,
    output logic [25:0] addr,
    output logic [5:0] ba,
    output logic [1:0] csN, rasN, casN, weN, dqsBurst, wdataValid, doingRd,
    output logic [31:0] wdata
);
    typedef struct packed {
        logic [1:0] cs, rd, bu, va;
        logic wr;
        logic [31:0] dt;
    } hrpci_slot_s;
    // Slot 0 goes out next controller cycle; later slots hold the tails of transfers.
    hrpci_slot_s q[8] = '{default: '0};
    int seed = 48694;
    logic [31:0] mask;

    task automatic put(input int k, input logic [1:0] c, r, b, v, input logic w,
                       input logic [31:0] d);
        logic [31:0] m;
        m = {{16{v[1]}}, {16{v[0]}}};
        q[k] = q[k] | {c, r, b, v, w, 32'h0};
        q[k].dt = (q[k].dt & ~m) | (d & m);
    endtask : put

    task automatic issue(input int kind, input logic [31:0] d);
        case (kind)
            0: begin
                put(0, 2'b10, 2'b00, 2'b00, 2'b00, 1'b1, '0);
                put(int'(wlat) - 1, 2'b00, 2'b00, 2'b10, 2'b00, 1'b0, '0);
                put(int'(wlat), 2'b00, 2'b00, 2'b11, 2'b11, 1'b0, d);
            end
            1: begin
                put(0, 2'b01, 2'b00, 2'b00, 2'b00, 1'b1, '0);
                put(int'(wlat) - 1, 2'b00, 2'b00, 2'b11, 2'b10, 1'b0, {d[15:0], 16'h0});
                put(int'(wlat), 2'b00, 2'b00, 2'b01, 2'b01, 1'b0, {16'h0, d[31:16]});
            end
            2: begin
                put(0, 2'b10, 2'b11, 2'b00, 2'b00, 1'b0, '0);
                put(1, 2'b00, 2'b11, 2'b00, 2'b00, 1'b0, '0);
            end
            default: begin
                put(0, 2'b00, 2'b10, 2'b00, 2'b00, 1'b0, '0);
                put(1, 2'b01, 2'b11, 2'b00, 2'b00, 1'b0, '0);
                put(2, 2'b00, 2'b01, 2'b00, 2'b00, 1'b0, '0);
            end
        endcase
    endtask : issue

    task automatic drv();
        mask = {{16{q[0].va[1]}}, {16{q[0].va[0]}}};
        csN = ~q[0].cs;
        casN = ~q[0].cs;
        weN = q[0].wr ? ~q[0].cs : 2'b11;
        rasN = 2'($random(seed)) | q[0].cs;
        addr = 26'($random(seed));
        ba = 6'($random(seed));
        doingRd = q[0].rd;
        dqsBurst = q[0].bu;
        wdataValid = q[0].va;
        // Unused halves carry noise, so a lane mix-up cannot pass by luck.
        wdata = (q[0].dt & mask) | ($random(seed) & ~mask);
    endtask : drv

    initial drv();
    always @(posedge sys_clk) begin
        if (ctrlCycleEn) begin
            #1;
            drv();
            for (int i = 0; i < 7; i++) q[i] = q[i+1];
            q[7] = '0;
        end
    end
endmodule : hrpci_ctrl_model
`default_nettype wire

// File: hrpci_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module hrpci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0] wptr;
        logic [PW:0] rptr;
    } hrpci_fifo_s;

    hrpci_fifo_s fifo_reg;
    hrpci_fifo_s fifo_next;
    logic fullNow;
    logic emptyNow;

    assign fullNow = (fifo_reg.wptr[PW] != fifo_reg.rptr[PW])
                     && (fifo_reg.wptr[PW-1:0] == fifo_reg.rptr[PW-1:0]);
    assign emptyNow = (fifo_reg.wptr == fifo_reg.rptr);
    assign inReady = !fullNow;
    assign outValid = !emptyNow;
    assign outData = fifo_reg.mem[fifo_reg.rptr[PW-1:0]];

    always_comb begin
        fifo_next = fifo_reg;
        if (inValid && !fullNow) begin
            fifo_next.mem[fifo_reg.wptr[PW-1:0]] = inData;
            fifo_next.wptr = fifo_reg.wptr + 1'b1;
        end
        if (outReady && !emptyNow) begin
            fifo_next.rptr = fifo_reg.rptr + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

endmodule : hrpci_fifo

`default_nettype wire

// File: hrpci_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module hrpci_monitor #(
    parameter int ADDR_WIDTH = 13, parameter int CS_WIDTH = 1, parameter int DQS_WIDTH = 1,
    parameter logic [4:0] WRITE_LAT = 5'h02, parameter logic [4:0] READ_LAT = 5'h0F
) (
    input wire logic sys_clk, rst, ctrlCycleEn, calSuccess, wdataReady, memRasN,
    input wire logic [ADDR_WIDTH*2-1:0] addr,
    input wire logic [CS_WIDTH*2-1:0] csN,
    input wire logic [1:0] rasN,
    input wire logic [DQS_WIDTH*2-1:0] doingRd, rdataValid,
    input wire logic [4:0] wlat, rlat,
    input wire logic [ADDR_WIDTH-1:0] memAddr,
    input wire logic [CS_WIDTH-1:0] memCsN,
    input wire logic [DQS_WIDTH-1:0] memDqOe, memDqsBurst
);
    // The sample is taken into the delay line at the boundary edge itself, and each
    // later stage costs one controller cycle, so the last stage shows it one memory
    // cycle short of READ_LAT controller cycles after that edge.
    localparam int RD_DLY = 2 * READ_LAT - 1;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    cmd_first_slice_a: assert property (!ctrlCycleEn && calSuccess |=>
        memCsN == $past(csN[CS_WIDTH-1:0]) && memAddr == $past(addr[ADDR_WIDTH-1:0]))
        else $error("first command slice missing on pins");
    cmd_second_slice_a: assert property (ctrlCycleEn && calSuccess |=>
        memCsN == $past(csN[CS_WIDTH+:CS_WIDTH]) && memRasN == $past(rasN[1]))
        else $error("second command slice missing on pins");
    ctrl_cycle_a: assert property (ctrlCycleEn |=> !ctrlCycleEn ##1 ctrlCycleEn)
        else $error("controller cycle is not two memory cycles");
    lat_outputs_a: assert property (wlat == (calSuccess ? WRITE_LAT : 5'h00)
        && rlat == (calSuccess ? READ_LAT : 5'h00)) else $error("latency outputs wrong");
    cal_hold_a: assert property (calSuccess |=> calSuccess && $stable(wlat))
        else $error("calibration result changed");
    rd_valid_lat_a: assert property (ctrlCycleEn && calSuccess |-> ##RD_DLY
        rdataValid == $past(doingRd, RD_DLY)) else $error("read valid latency wrong");
    rd_idle_a: assert property (!calSuccess |-> rdataValid == '0)
        else $error("read valid before calibration");
    rdv_boundary_a: assert property (!$stable(rdataValid) |-> $past(ctrlCycleEn))
        else $error("read valid moved inside a controller cycle");
    oe_burst_a: assert property (|memDqOe |-> (memDqsBurst & memDqOe) == memDqOe)
        else $error("data driven without strobe burst");
    cover property (rdataValid == 2'b10);
    cover property ($rose(memDqOe[0]));
    cover property (!wdataReady);
endmodule : hrpci_monitor

bind hrpci_phy_top hrpci_monitor #(.ADDR_WIDTH(ADDR_WIDTH), .CS_WIDTH(CS_WIDTH),
    .DQS_WIDTH(DQS_WIDTH), .WRITE_LAT(WRITE_LAT), .READ_LAT(READ_LAT)) u_hrpci_monitor (
    .sys_clk, .rst, .ctrlCycleEn, .calSuccess, .wdataReady, .memRasN, .addr, .csN, .rasN,
    .doingRd, .rdataValid, .wlat, .rlat, .memAddr, .memCsN, .memDqOe, .memDqsBurst);
`default_nettype wire

// File: hrpci_phy_top.sv
`timescale 1ns/10ps
`default_nettype none

module hrpci_phy_top
    import hrpci_pkg::*;
#(
    parameter int RATE_RATIO = DEF_RATE_RATIO,
    parameter int DQ_WIDTH = DEF_DQ_WIDTH,
    parameter int DQS_WIDTH = DEF_DQS_WIDTH,
    parameter int CS_WIDTH = DEF_CS_WIDTH,
    parameter int ADDR_WIDTH = DEF_ADDR_WIDTH,
    parameter int BA_WIDTH = DEF_BA_WIDTH,
    parameter int FIFO_DEPTH = DEF_FIFO_DEPTH,
    parameter logic [4:0] WRITE_LAT = DEF_WRITE_LAT,
    parameter logic [4:0] READ_LAT = DEF_READ_LAT
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic ctrlCycleEn,
    input wire logic [ADDR_WIDTH*RATE_RATIO/2-1:0] addr,
    input wire logic [BA_WIDTH*RATE_RATIO/2-1:0] ba,
    input wire logic [CS_WIDTH*RATE_RATIO/2-1:0] csN,
    input wire logic [CS_WIDTH*RATE_RATIO/2-1:0] cke,
    input wire logic [CS_WIDTH*RATE_RATIO/2-1:0] odt,
    input wire logic [RATE_RATIO/2-1:0] rasN,
    input wire logic [RATE_RATIO/2-1:0] casN,
    input wire logic [RATE_RATIO/2-1:0] weN,
    input wire logic [DQS_WIDTH*RATE_RATIO/2-1:0] dqsBurst,
    input wire logic [DQS_WIDTH*RATE_RATIO/2-1:0] wdataValid,
    input wire logic [DQ_WIDTH*RATE_RATIO-1:0] wdata,
    output logic wdataReady,
    input wire logic [DQS_WIDTH*RATE_RATIO/2-1:0] doingRd,
    output logic [DQ_WIDTH*RATE_RATIO-1:0] rdata,
    output logic [DQS_WIDTH*RATE_RATIO/2-1:0] rdataValid,
    output logic [4:0] wlat,
    output logic [4:0] rlat,
    output logic calSuccess,
    output logic [ADDR_WIDTH-1:0] memAddr,
    output logic [BA_WIDTH-1:0] memBa,
    output logic [CS_WIDTH-1:0] memCsN,
    output logic [CS_WIDTH-1:0] memCke,
    output logic [CS_WIDTH-1:0] memOdt,
    output logic memRasN,
    output logic memCasN,
    output logic memWeN,
    output logic [2*DQ_WIDTH-1:0] memDqOut,
    output logic [DQS_WIDTH-1:0] memDqOe,
    output logic [DQS_WIDTH-1:0] memDqsBurst,
    input wire logic [2*DQ_WIDTH-1:0] memDqIn
);
    localparam int HALF = RATE_RATIO / 2;
    localparam int WW = DQ_WIDTH * RATE_RATIO;
    localparam int GW = DQS_WIDTH * HALF;
    localparam int FW = WW + 2 * GW;
    localparam int MW = 2 * DQ_WIDTH;

    typedef struct packed {
        hrpci_state_e state;
        logic [15:0] cnt;
        logic [1:0] mrsIdx;
        logic phase;
        logic calSuccess;
        logic [4:0] wlat;
        logic [4:0] rlat;
        logic [ADDR_WIDTH-1:0] memAddr;
        logic [BA_WIDTH-1:0] memBa;
        logic [CS_WIDTH-1:0] memCsN;
        logic [CS_WIDTH-1:0] memCke;
        logic [CS_WIDTH-1:0] memOdt;
        logic memRasN;
        logic memCasN;
        logic memWeN;
        logic [MW-1:0] memDqOut;
        logic [DQS_WIDTH-1:0] memDqOe;
        logic [DQS_WIDTH-1:0] memDqsBurst;
        logic [MW-1:0] dqMeta;
        logic [MW-1:0] dqSync;
        logic [WW-1:0] rdAsm;
        logic [WW-1:0] rdata;
        logic [READ_LAT-1:0][GW-1:0] rdPipe;
    } hrpci_top_s;

    hrpci_top_s top_reg;
    hrpci_top_s top_next;

    logic [FW-1:0] fifoIn;
    logic [FW-1:0] fifoOut;
    logic fifoOutValid;
    logic fifoPush;
    logic fifoPop;
    logic [WW-1:0] headData;
    logic [GW-1:0] headBurst;
    logic [GW-1:0] headValid;

    // One controller cycle spans HALF memory cycles; the last one is the boundary.
    assign ctrlCycleEn = (HALF == 1) ? 1'b1 : top_reg.phase;

    // Write traffic is buffered so data, strobe burst and valid stay together.
    // Draining is held off until calibration is done, which lets the buffer fill.
    assign fifoIn = {dqsBurst, wdataValid, wdata};
    assign fifoPush = ctrlCycleEn && ((|dqsBurst) || (|wdataValid));
    assign fifoPop = ctrlCycleEn && top_reg.calSuccess;
    assign headData = fifoOut[WW-1:0];
    assign headValid = fifoOut[WW +: GW];
    assign headBurst = fifoOut[WW+GW +: GW];

    hrpci_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) wrBuf (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(fifoPush),
        .inReady(wdataReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOut)
    );

    always_comb begin
        top_next = top_reg;
        top_next.phase = (HALF == 2) ? ~top_reg.phase : 1'b0;
        top_next.dqMeta = memDqIn;
        top_next.dqSync = top_reg.dqMeta;

        top_next.memCsN = '1;
        top_next.memRasN = 1'b1;
        top_next.memCasN = 1'b1;
        top_next.memWeN = 1'b1;
        top_next.memOdt = '0;
        top_next.memAddr = '0;
        top_next.memBa = '0;
        top_next.memDqOe = '0;
        top_next.memDqsBurst = '0;

        case (top_reg.state)
            ST_INIT: begin
                top_next.memCke = '0;
                top_next.cnt = top_reg.cnt + 16'h0001;
                if (top_reg.cnt == 16'(INIT_CYCLES - 1)) begin
                    top_next.cnt = '0;
                    top_next.state = ST_MRS;
                end
            end
            ST_MRS: begin
                // Mode register write on the first cycle, then idle for the
                // mode-register spacing before the next one.
                top_next.memCke = '1;
                top_next.cnt = top_reg.cnt + 16'h0001;
                if (top_reg.cnt == 16'h0000) begin
                    top_next.memCsN = '0;
                    top_next.memRasN = 1'b0;
                    top_next.memCasN = 1'b0;
                    top_next.memWeN = 1'b0;
                    top_next.memBa = BA_WIDTH'(top_reg.mrsIdx);
                end
                if (top_reg.cnt == 16'(MRD_CYCLES)) begin
                    top_next.cnt = '0;
                    top_next.mrsIdx = top_reg.mrsIdx + 2'h1;
                    if (top_reg.mrsIdx == 2'(MRS_COUNT - 1)) begin
                        top_next.state = ST_CAL;
                    end
                end
            end
            ST_CAL: begin
                top_next.cnt = top_reg.cnt + 16'h0001;
                if (top_reg.cnt == 16'(CAL_CYCLES - 1)) begin
                    top_next.cnt = '0;
                    top_next.calSuccess = 1'b1;
                    top_next.wlat = WRITE_LAT;
                    top_next.rlat = READ_LAT;
                    top_next.state = ST_READY;
                end
            end
            ST_READY: begin
                // Slice selected by phase: bit 0 of each pin pair goes out first.
                top_next.memAddr = addr[top_reg.phase*ADDR_WIDTH +: ADDR_WIDTH];
                top_next.memBa = ba[top_reg.phase*BA_WIDTH +: BA_WIDTH];
                top_next.memCsN = csN[top_reg.phase*CS_WIDTH +: CS_WIDTH];
                top_next.memCke = cke[top_reg.phase*CS_WIDTH +: CS_WIDTH];
                top_next.memOdt = odt[top_reg.phase*CS_WIDTH +: CS_WIDTH];
                top_next.memRasN = rasN[top_reg.phase];
                top_next.memCasN = casN[top_reg.phase];
                top_next.memWeN = weN[top_reg.phase];
                if (fifoOutValid) begin
                    // Each valid bit gates one memory-width half; the other
                    // half of an unaligned first or last beat is not driven.
                    top_next.memDqOut = headData[top_reg.phase*MW +: MW];
                    top_next.memDqOe = headValid[top_reg.phase*DQS_WIDTH +: DQS_WIDTH];
                    top_next.memDqsBurst = headBurst[top_reg.phase*DQS_WIDTH +: DQS_WIDTH];
                end
            end
            default: begin
                top_next.state = ST_INIT;
                top_next.cnt = '0;
            end
        endcase

        // Read capture: each memory cycle fills its slice of the assembly word.
        top_next.rdAsm[top_reg.phase*MW +: MW] = top_reg.dqSync;
        if (ctrlCycleEn) begin
            top_next.rdata = top_next.rdAsm;
            // Fixed delay line keeps spaced and back-to-back reads in step.
            top_next.rdPipe[0] = top_reg.calSuccess ? doingRd : '0;
            for (int i = 1; i < READ_LAT; i++) begin
                top_next.rdPipe[i] = top_reg.rdPipe[i-1];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            top_reg <= '0;
            top_reg.state <= ST_INIT;
            top_reg.wlat <= LAT_RESET;
            top_reg.rlat <= LAT_RESET;
            top_reg.memCsN <= '1;
            top_reg.memRasN <= 1'b1;
            top_reg.memCasN <= 1'b1;
            top_reg.memWeN <= 1'b1;
        end else begin
            top_reg <= top_next;
        end
    end

    // Write latency seen at the pins is the command-to-data distance plus the one
    // controller cycle spent in the buffer; an unaligned write starts one memory cycle earlier.
    assign wlat = top_reg.wlat;
    assign rlat = top_reg.rlat;
    assign calSuccess = top_reg.calSuccess;
    assign rdata = top_reg.rdata;
    assign rdataValid = top_reg.rdPipe[READ_LAT-1];
    assign memAddr = top_reg.memAddr;
    assign memBa = top_reg.memBa;
    assign memCsN = top_reg.memCsN;
    assign memCke = top_reg.memCke;
    assign memOdt = top_reg.memOdt;
    assign memRasN = top_reg.memRasN;
    assign memCasN = top_reg.memCasN;
    assign memWeN = top_reg.memWeN;
    assign memDqOut = top_reg.memDqOut;
    assign memDqOe = top_reg.memDqOe;
    assign memDqsBurst = top_reg.memDqsBurst;

endmodule : hrpci_phy_top

`default_nettype wire

// File: hrpci_pkg.sv
package hrpci_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int INIT_TIME_NS = 200000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MRD_TIME_NS = 200;
    localparam int MRD_CYCLES = (MRD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MRS_COUNT = 4;
    localparam int CAL_CYCLES = 16;

    localparam int DEF_RATE_RATIO = 4;
    localparam int DEF_DQ_WIDTH = 8;
    localparam int DEF_DQS_WIDTH = 1;
    localparam int DEF_CS_WIDTH = 1;
    localparam int DEF_ADDR_WIDTH = 13;
    localparam int DEF_BA_WIDTH = 3;
    localparam int DEF_FIFO_DEPTH = 16;
    localparam int LAT_WIDTH = 5;
    localparam logic [4:0] DEF_WRITE_LAT = 5'h02;
    localparam logic [4:0] DEF_READ_LAT = 5'h0F;
    localparam logic [4:0] LAT_RESET = 5'h00;

    typedef enum logic [3:0] {
        ST_INIT = 4'h1,
        ST_MRS = 4'h2,
        ST_CAL = 4'h4,
        ST_READY = 4'h8
    } hrpci_state_e;

endpackage : hrpci_pkg

// File: hrpci_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import hrpci_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic ctrlCycleEn, wdataReady, calSuccess, memRasN, memCasN, memWeN;
    logic memCsN, memCke, memOdt, memDqOe, memDqsBurst;
    logic [1:0] csN, rasN, casN, weN, dqsBurst, wdataValid, doingRd, rdataValid;
    logic [25:0] addr;
    logic [5:0] ba;
    logic [31:0] wdata, rdata, d1, d2;
    logic [4:0] wlat, rlat;
    logic [12:0] memAddr;
    logic [2:0] memBa;
    logic [15:0] memDqOut, memDqIn = 16'h0000;
    logic [15:0] got[$];
    logic [1:0] rdExp[6] = '{2'b11, 2'b11, 2'b10, 2'b11, 2'b01, 2'b00};
    int fails = 0, n_compared = 0, seed = 48694, cyc = 0, nMrs = 0, fa, f, acc;

    hrpci_phy_top u_hrpci_phy_top (.sys_clk, .rst, .ctrlCycleEn, .addr, .ba, .csN,
        .cke(2'b11), .odt(2'b00), .rasN, .casN, .weN, .dqsBurst, .wdataValid, .wdata,
        .wdataReady, .doingRd, .rdata, .rdataValid, .wlat, .rlat, .calSuccess, .memAddr,
        .memBa, .memCsN, .memCke, .memOdt, .memRasN, .memCasN, .memWeN, .memDqOut,
        .memDqOe, .memDqsBurst, .memDqIn);
    hrpci_ctrl_model u_hrpci_ctrl_model (.sys_clk, .ctrlCycleEn, .wlat, .addr, .ba, .csN,
        .rasN, .casN, .weN, .dqsBurst, .wdataValid, .doingRd, .wdata);

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        #1 memDqIn = 16'($random(seed));
        cyc++;
        if (cyc == 6000) begin
            fails++;
            test_done();
        end
    end
    always @(negedge sys_clk) if (!rst && calSuccess !== 1'b1 && memCsN === 1'b0) nMrs++;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic step();
        @(posedge sys_clk iff ctrlCycleEn);
        @(negedge sys_clk);
    endtask : step

    task automatic gather(input int n, output int first);
        int t;
        t = 0;
        first = -1;
        got = {};
        while (got.size() < n && t < 200) begin
            @(negedge sys_clk);
            if (memDqOe === 1'b1 && first < 0) first = t;
            if (memDqOe === 1'b1) got.push_back(memDqOut);
            t++;
        end
    endtask : gather

    // Half k of a word leaves on the pins as memory cycle k, lowest byte first.
    function automatic logic [15:0] lane(input logic [31:0] d, input int k);
        return d[16*k +: 16];
    endfunction : lane

    initial begin
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        check("wlat_pre", wlat, 5'h00);
        acc = 0;
        // Pushes before calibration fill the buffer, so two of eighteen are refused.
        for (int k = 0; k <= 18; k++) begin
            step();
            if (k > 0 && wdataReady === 1'b1) acc++;
            if (k < 18) u_hrpci_ctrl_model.put(0, 2'b00, 2'b00, 2'b11, 2'b11, 1'b0, $random(seed));
        end
        check("accepted", acc, DEF_FIFO_DEPTH);
        while (calSuccess !== 1'b1) @(negedge sys_clk);
        check("mode_writes", nMrs, MRS_COUNT);
        check("wlat", wlat, DEF_WRITE_LAT);
        check("rlat", rlat, DEF_READ_LAT);
        gather(2 * DEF_FIFO_DEPTH + 1, f);
        check("drained", got.size(), 2 * DEF_FIFO_DEPTH);
        check("ready", wdataReady, 1'b1);
        for (int i = 0; i < 6; i++) begin
            d1 = $random(seed);
            step();
            u_hrpci_ctrl_model.issue(i % 2, d1);
            gather(2, f);
            check("wr_first", got[0], lane(d1, 0));
            check("wr_last", got[1], lane(d1, 1));
            @(negedge sys_clk);
            check("oe_end", memDqOe, 1'b0);
            if (i % 2 == 0) fa = f;
            else check("wr_lat", f, fa - 1);
        end
        d1 = $random(seed);
        d2 = $random(seed);
        step();
        u_hrpci_ctrl_model.issue(0, d1);
        repeat (2) step();
        u_hrpci_ctrl_model.issue(1, d2);
        gather(4, f);
        for (int k = 0; k < 4; k++) check("spaced_wr", got[k], lane(k < 2 ? d1 : d2, k % 2));
        step();
        u_hrpci_ctrl_model.issue(2, '0);
        repeat (2) step();
        u_hrpci_ctrl_model.issue(3, '0);
        f = 0;
        while (rdataValid === 2'b00 && f < 80) begin
            @(negedge sys_clk);
            f++;
        end
        for (int k = 0; k < 6; k++) begin
            check("rd_valid", rdataValid, rdExp[k]);
            repeat (2) @(negedge sys_clk);
        end
        @(posedge sys_clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 check("cal_reset", calSuccess, 1'b0);
        check("wlat_reset", wlat, 5'h00);
        test_done();
    end
endmodule : testbench
`default_nettype wire
